// *** srcr_pkg.sv ***
// shared constants for the sysref control register group
package srcr_pkg;
  localparam logic [7:0] ADDR_RATE_DIV   = 8'h38;
  localparam logic [7:0] ADDR_WAIT_CNT   = 8'h3a;
  localparam logic [7:0] ADDR_PULSE_CNT  = 8'h3b;
  localparam logic [7:0] ADDR_MODE       = 8'h3d;
  localparam int         RATE_DIV_LSB    = 4;
  localparam int         OUT_CTRL_LSB    = 3;
  localparam logic [3:0] RST_RATE_DIV    = 4'h0;
  localparam logic [3:0] MAX_RATE_DIV    = 4'hc;
  localparam logic [7:0] RST_WAIT_CNT    = 8'h00;
  localparam logic [7:0] RST_PULSE_CNT   = 8'h01;
  localparam logic [2:0] RST_GEN_MODE    = 3'h3;
  localparam logic [1:0] RST_OUT_CTRL    = 2'h0;
  localparam logic [2:0] MODE_FANOUT     = 3'h0;
  localparam int         STAGE_MAX       = 4096;
endpackage : srcr_pkg

// *** srcr_regs.sv ***
// sysref control registers with rate divider and pulse generator
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - The sysref rate is divided by two to the 4-bit code after the channel divider, code 0 (reset) is divide-by-one.
// - One rate-divider setting serves every sysref-configured channel.
// - The rate code sits in bits 7:4 at 0x38 and bits 3:0 are reserved.
// - Wait count is at 0x3a, pulse count at 0x3b, and 0x3d holds output control above generation mode.
// - Codes 0 to 12 divide by two to the code and codes 13 to 15 are reserved.
// - The generator waits the wait count in divided ticks between one series and the next, resetting to zero.
// - The pulse count, resetting to one, sets the pulses sent per series.
// - Generation mode zero passes the external sync input out through the two-stage synchroniser and one output register.
module srcr_regs (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // configuration port
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  // sysref path
  input  wire logic       div_tick,
  input  wire logic       external_sync_input,
  output logic            sysref_out,
  output logic      [1:0] sysref_output_control
);
  logic [3:0]  rate_ff, nxt_rate;
  logic [7:0]  wait_ff, nxt_wait, pcnt_ff, nxt_pcnt, rdata_ff, nxt_rdata;
  logic [2:0]  mode_ff, nxt_mode;
  logic [1:0]  octl_ff, nxt_octl;
  logic [11:0] div_ff, nxt_div;
  logic [7:0]  run_ff, nxt_run;
  logic        burst_ff, nxt_burst, out_ff, nxt_out;
  logic        ext_s1_ff, ext_s2_ff, tick_s1_ff, tick_s2_ff, tick_d_ff;
  logic        tick_rise, rate_tick;
  logic [11:0] div_mask;

  // two-stage synchronisers for pin inputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_ff  <= 1'b0;
      ext_s2_ff  <= 1'b0;
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
      tick_d_ff  <= 1'b0;
    end else begin
      ext_s1_ff  <= external_sync_input;
      ext_s2_ff  <= ext_s1_ff;
      tick_s1_ff <= div_tick;
      tick_s2_ff <= tick_s1_ff;
      tick_d_ff  <= tick_s2_ff;
    end
  end
  assign tick_rise = tick_s2_ff & ~tick_d_ff;

  // register writes and reads
  always_comb begin
    nxt_rate  = rate_ff;
    nxt_wait  = wait_ff;
    nxt_pcnt  = pcnt_ff;
    nxt_mode  = mode_ff;
    nxt_octl  = octl_ff;
    nxt_rdata = rdata_ff;
    if (cfg_wr) begin
      unique case (cfg_addr)
        srcr_pkg::ADDR_RATE_DIV: begin
          if (cfg_wdata[7:4] <= srcr_pkg::MAX_RATE_DIV) begin
            nxt_rate = cfg_wdata[7:4];
          end
        end
        srcr_pkg::ADDR_WAIT_CNT:  nxt_wait = cfg_wdata;
        srcr_pkg::ADDR_PULSE_CNT: nxt_pcnt = cfg_wdata;
        srcr_pkg::ADDR_MODE: begin
          nxt_mode = cfg_wdata[2:0];
          nxt_octl = cfg_wdata[4:3];
        end
        default: ;
      endcase
    end
    if (cfg_rd) begin
      unique case (cfg_addr)
        srcr_pkg::ADDR_RATE_DIV:  nxt_rdata = {rate_ff, 4'h0};
        srcr_pkg::ADDR_WAIT_CNT:  nxt_rdata = wait_ff;
        srcr_pkg::ADDR_PULSE_CNT: nxt_rdata = pcnt_ff;
        srcr_pkg::ADDR_MODE:      nxt_rdata = {3'h0, octl_ff, mode_ff};
        default:                  nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_ff  <= srcr_pkg::RST_RATE_DIV;
      wait_ff  <= srcr_pkg::RST_WAIT_CNT;
      pcnt_ff  <= srcr_pkg::RST_PULSE_CNT;
      mode_ff  <= srcr_pkg::RST_GEN_MODE;
      octl_ff  <= srcr_pkg::RST_OUT_CTRL;
      rdata_ff <= 8'h00;
    end else begin
      rate_ff  <= nxt_rate;
      wait_ff  <= nxt_wait;
      pcnt_ff  <= nxt_pcnt;
      mode_ff  <= nxt_mode;
      octl_ff  <= nxt_octl;
      rdata_ff <= nxt_rdata;
    end
  end
  assign cfg_rdata             = rdata_ff;
  assign sysref_output_control = octl_ff;

  // one shared divider for all channels
  assign div_mask  = 12'((13'h1 << rate_ff) - 13'h1);

  // divider counter must span the largest legal code
  if (2 ** srcr_pkg::MAX_RATE_DIV > srcr_pkg::STAGE_MAX) begin : g_div_fit
    $error("divider counter too narrow for the largest rate code");
  end
  assign rate_tick = tick_rise && ((div_ff & div_mask) == 12'h000);

  // pulse series: burst of pcnt pulses, then wait divided ticks held low
  always_comb begin
    nxt_div   = div_ff;
    nxt_run   = run_ff;
    nxt_burst = burst_ff;
    nxt_out   = out_ff;
    if (tick_rise) begin
      nxt_div = 12'((div_ff + 12'h001) & div_mask);
    end
    if (mode_ff == srcr_pkg::MODE_FANOUT) begin
      nxt_out   = ext_s2_ff;
      nxt_run   = 8'h00;
      nxt_burst = 1'b1;
    end else if (rate_tick) begin
      if (burst_ff) begin
        nxt_out = ~out_ff;
        if (out_ff) begin
          nxt_run = 8'(run_ff + 8'h01);
          if (8'(run_ff + 8'h01) >= pcnt_ff) begin
            nxt_run   = 8'h00;
            nxt_burst = (wait_ff == 8'h00);
          end
        end
      end else begin
        nxt_out = 1'b0;
        nxt_run = 8'(run_ff + 8'h01);
        if (8'(run_ff + 8'h01) >= wait_ff) begin
          nxt_run   = 8'h00;
          nxt_burst = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff   <= 12'h000;
      run_ff   <= 8'h00;
      burst_ff <= 1'b1;
      out_ff   <= 1'b0;
    end else begin
      div_ff   <= nxt_div;
      run_ff   <= nxt_run;
      burst_ff <= nxt_burst;
      out_ff   <= nxt_out;
    end
  end
  assign sysref_out = out_ff;

  // checks
  chk_rate_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rate_ff <= srcr_pkg::MAX_RATE_DIV) else $error("rate code reserved");
  chk_rate_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == srcr_pkg::ADDR_RATE_DIV && cfg_wdata[7:4] < 4'hd
    |=> rate_ff == $past(cfg_wdata[7:4])) else $error("rate not written");
  chk_rate_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == srcr_pkg::ADDR_RATE_DIV
    |=> cfg_rdata == {$past(rate_ff), 4'h0}) else $error("rate readback");
  chk_wait_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == srcr_pkg::ADDR_WAIT_CNT
    |=> wait_ff == $past(cfg_wdata)) else $error("wait not written");
  chk_pcnt_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == srcr_pkg::ADDR_PULSE_CNT
    |=> pcnt_ff == $past(cfg_wdata)) else $error("pulse count");
  chk_octl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == srcr_pkg::ADDR_MODE
    |=> sysref_output_control == $past(cfg_wdata[4:3]))
    else $error("output control not written");
  chk_mode_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == srcr_pkg::ADDR_MODE
    |=> cfg_rdata[7:5] == 3'h0) else $error("mode reserved bits");
  chk_fanout_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_ff == srcr_pkg::MODE_FANOUT && $stable(mode_ff)
    |=> sysref_out == $past(ext_s2_ff)) else $error("fanout broken");
  chk_div_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rate_ff == 4'h0 && tick_rise && burst_ff
    && mode_ff != srcr_pkg::MODE_FANOUT
    |=> sysref_out != $past(sysref_out)) else $error("div1 wrong");
  chk_shared_div: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rate_tick && rate_ff != 4'h0
    |=> div_ff == 12'h001) else $error("div phase");
  chk_idle_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !burst_ff && mode_ff != srcr_pkg::MODE_FANOUT && rate_tick
    |=> !sysref_out) else $error("pulse in wait");
  chk_burst_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    burst_ff |-> run_ff < pcnt_ff || pcnt_ff == 8'h00) else $error("overrun");
  cov_fanout: cover property (@(posedge sys_clk) mode_ff == 3'h0 && sysref_out);
  cov_wait: cover property (@(posedge sys_clk) !burst_ff ##1 burst_ff);
  cov_div64: cover property (@(posedge sys_clk) rate_ff == 4'h6 && rate_tick);
  cov_pulse_two: cover property (@(posedge sys_clk)
    pcnt_ff == 8'h02 && !burst_ff && rate_tick);
  cov_rate_refused: cover property (@(posedge sys_clk)
    cfg_wr && cfg_addr == srcr_pkg::ADDR_RATE_DIV
    && cfg_wdata[7:4] > srcr_pkg::MAX_RATE_DIV);
endmodule : srcr_regs

`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the sysref control register group
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cfg_wr = 1'b0;
  logic       cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic       div_tick = 1'b0;
  logic       external_sync_input = 1'b0;
  logic [7:0] cfg_rdata;
  logic       sysref_out;
  logic [1:0] sysref_output_control;
  logic       prev_out = 1'b0;
  int         edges = 0;
  int         cycles = 0;
  int         num_errors = 0;
  int         num_checks = 0;

  srcr_regs dut_u (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .cfg_wr               (cfg_wr),
    .cfg_rd               (cfg_rd),
    .cfg_addr             (cfg_addr),
    .cfg_wdata            (cfg_wdata),
    .cfg_rdata            (cfg_rdata),
    .div_tick             (div_tick),
    .external_sync_input  (external_sync_input),
    .sysref_out           (sysref_out),
    .sysref_output_control(sysref_output_control)
  );

  always #4 sys_clk = ~sys_clk;

  // rising edges of the sysref output, plus hang guard
  always @(posedge sys_clk) begin
    if (sysref_out === 1'b1 && prev_out === 1'b0) edges++;
    prev_out <= sysref_out;
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    `CMP("cfg_rdata", e, cfg_rdata)
  endtask

  // edges of the channel divider, long enough for the synchroniser
  // tick rate far below limit
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      div_tick <= 1'b1;
      repeat (4) @(posedge sys_clk);
      div_tick <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc(8'h38, 8'h00);
    rc(8'h3a, 8'h00);
    rc(8'h3b, 8'h01);
    rc(8'h3d, 8'h03);
    `CMP("out_ctrl", 2'h0, sysref_output_control)
    wr(8'h38, 8'hcf);
    rc(8'h38, 8'hc0);
    wr(8'h38, 8'hd5);
    rc(8'h38, 8'hc0);
    wr(8'h3a, 8'ha5);
    rc(8'h3a, 8'ha5);
    wr(8'h3b, 8'h5a);
    rc(8'h3b, 8'h5a);
    wr(8'h3d, 8'hf4);
    rc(8'h3d, 8'h14);
    `CMP("out_ctrl", 2'h2, sysref_output_control)
    wr(8'h39, 8'hff);
    rc(8'h39, 8'h00);
    wr(8'h3d, 8'h00);
    @(posedge sys_clk) external_sync_input <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CMP("fanout", 1'b1, sysref_out)
    external_sync_input <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CMP("fanout", 1'b0, sysref_out)
    wr(8'h3d, 8'h03);
    wr(8'h3b, 8'h01);
    wr(8'h3a, 8'h00);
    wr(8'h38, 8'h00);
    edges = 0;
    tick(32);
    `CMP("edges_div1", 16, edges)
    wr(8'h38, 8'h10);
    edges = 0;
    tick(32);
    `CMP("edges_div2", 8, edges)
    wr(8'h3b, 8'h02);
    wr(8'h3a, 8'h03);
    wr(8'h38, 8'h00);
    edges = 0;
    tick(4);
    `CMP("edges_burst", 2, edges)
    tick(10);
    `CMP("edges_series", 4, edges)
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
